/* core/counter_evt_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module counter_evt_gate
  import mac_irq_mask_pkg::*;
(
  // Counter threshold events
  input  wire evt_vec_t i_half,
  input  wire evt_vec_t i_full,
  // Mask bits, one per counter
  input  wire evt_vec_t i_mask,
  // Gated events
  output wire evt_vec_t o_evt
);

  // Both thresholds of a counter share its one mask bit.
  assign o_evt = (i_half | i_full) & ~i_mask;

endmodule : counter_evt_gate
`default_nettype wire

/* core/mac_irq_mask_defines.svh */
`ifndef MAC_IRQ_MASK_DEFINES_SVH
`define MAC_IRQ_MASK_DEFINES_SVH

// Register byte offsets.
`define OFS_TX_MASK      12'h110
`define OFS_RX_MASK      12'h10C
`define OFS_IRQ_STATUS   12'h120
`define OFS_IRQ_CLEAR    12'h124
`define OFS_IRQ_ENABLE   12'h128

// Field widths and positions.
`define TX_MASK_W        25
`define RX_MASK_W        3
`define EVT_W            28
`define STAT_RX_LSB      25

// Reset values.
`define RST_TX_MASK      25'h0000000
`define RST_RX_MASK      3'h0
`define RST_EVT          28'h0000000
`define RST_WORD         32'h00000000

// Transmit mask bit positions.
`define TX_TAGGED        24
`define TX_FLOW_CTRL     23
`define TX_EXC_DEFER     22
`define TX_GOOD_FRAME    21
`define TX_GOOD_OCTET    20
`define TX_CARRIER_ERR   19
`define TX_LATE_COLL     17
`define TX_UNDERFLOW     13
`define TX_ALL_BCAST     12
`define TX_ALL_MCAST     11
`define TX_ALL_UCAST     10
`define TX_LEN_1024_MAX  9
`define TX_LEN_UPTO_64   4
`define TX_GOOD_MCAST    3
`define TX_ALL_FRAME     1
`define TX_ALL_OCTET     0

// Receive mask bit positions.
`define RX_GOOD_OCTET    2
`define RX_ALL_OCTET     1
`define RX_ALL_FRAME     0

`endif

/* core/mac_irq_mask_pkg.sv */
`default_nettype none
package mac_irq_mask_pkg;
  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] reg_word_t;
  typedef logic [27:0] evt_vec_t;
endpackage : mac_irq_mask_pkg
`default_nettype wire

/* core/mac_stat_counter_irq_mask.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_irq_mask_defines.svh"
module mac_stat_counter_irq_mask
  import mac_irq_mask_pkg::*;
(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  // Register port
  input  wire reg_addr_t        i_addr,
  input  wire reg_word_t        i_wr_data,
  input  wire logic             i_wr_en,
  input  wire logic             i_rd_en,
  output var  reg_word_t        o_rd_data,
  // Counter threshold events, one-cycle pulses
  input  wire logic [24:0]      i_tx_half,
  input  wire logic [24:0]      i_tx_full,
  input  wire logic [2:0]       i_rx_half,
  input  wire logic [2:0]       i_rx_full,
  // Mask state for the counter block
  output var  logic [24:0]      o_tx_mask,
  output var  logic [2:0]       o_rx_mask,
  // Interrupt
  output var  logic             o_irq
);

  logic [`TX_MASK_W-1:0] tx_mask_r;
  logic [`RX_MASK_W-1:0] rx_mask_r;
  evt_vec_t              status_r;
  evt_vec_t              enable_r;
  evt_vec_t              status_nxt;
  reg_word_t             rd_data_r;
  reg_word_t             rd_data_nxt;
  logic                  irq_r;

  // Address decode.
  wire logic sel_tx_mask = (i_addr == `OFS_TX_MASK);
  wire logic sel_rx_mask = (i_addr == `OFS_RX_MASK);
  wire logic sel_status  = (i_addr == `OFS_IRQ_STATUS);
  wire logic sel_clear   = (i_addr == `OFS_IRQ_CLEAR);
  wire logic sel_enable  = (i_addr == `OFS_IRQ_ENABLE);

  wire logic wr_tx_mask  = i_wr_en && sel_tx_mask;
  wire logic wr_rx_mask  = i_wr_en && sel_rx_mask;
  wire logic wr_clear    = i_wr_en && sel_clear;
  wire logic wr_enable   = i_wr_en && sel_enable;

  // Places a status-layout vector in the low bits of a bus word.
  function automatic reg_word_t to_word(input evt_vec_t v);
    to_word = {4'h0, v};
  endfunction : to_word

  wire evt_vec_t all_half = {i_rx_half, i_tx_half};
  wire evt_vec_t all_full = {i_rx_full, i_tx_full};
  wire evt_vec_t all_mask = {rx_mask_r, tx_mask_r};
  wire evt_vec_t evt_raw  = all_half | all_full;
  evt_vec_t      evt_gated;

  counter_evt_gate u_gate (
    .i_half (all_half),
    .i_full (all_full),
    .i_mask (all_mask),
    .o_evt  (evt_gated)
  );

  // A new event wins over a clear in the same cycle.
  wire evt_vec_t clr_bits = wr_clear ? i_wr_data[`EVT_W-1:0] : `RST_EVT;
  assign status_nxt = (status_r & ~clr_bits) | evt_gated;

  assign rd_data_nxt = !i_rd_en    ? `RST_WORD :
                       sel_tx_mask ? {7'h00, tx_mask_r} :
                       sel_rx_mask ? {29'h0, rx_mask_r} :
                       sel_status  ? to_word(status_r) :
                       sel_enable  ? to_word(enable_r) :
                                     `RST_WORD;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      tx_mask_r <= `RST_TX_MASK;
    end
    else if (wr_tx_mask)
    begin
      tx_mask_r <= i_wr_data[`TX_MASK_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      rx_mask_r <= `RST_RX_MASK;
    end
    else if (wr_rx_mask)
    begin
      rx_mask_r <= i_wr_data[`RX_MASK_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      enable_r <= `RST_EVT;
    end
    else if (wr_enable)
    begin
      enable_r <= i_wr_data[`EVT_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      status_r <= `RST_EVT;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & enable_r);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      rd_data_r <= `RST_WORD;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_tx_mask = tx_mask_r;
  assign o_rx_mask = rx_mask_r;
  assign o_irq     = irq_r;

  // Checks on the design's own behaviour.

  sequence seq_rd_tx_mask;
    i_rd_en && sel_tx_mask;
  endsequence

  sequence seq_wr_tx_mask;
    i_wr_en && sel_tx_mask;
  endsequence

  sequence seq_wr_rx_mask;
    i_wr_en && sel_rx_mask;
  endsequence

  a_tx_mask_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    seq_wr_tx_mask |=> (o_tx_mask == $past(i_wr_data[`TX_MASK_W-1:0])))
    else $error("Transmit mask write did not take.");

  a_tx_rsvd_zero: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    seq_rd_tx_mask |=> (o_rd_data == {7'h00, $past(tx_mask_r)}))
    else $error("Transmit mask read back wrong or reserved bits set.");

  a_masks_reset: assert property (
    @(posedge i_ref_clk)
    !i_rst_n |=> (o_tx_mask == `RST_TX_MASK) && (o_rx_mask == `RST_RX_MASK) && !o_irq)
    else $error("Masks or interrupt not clear after reset.");

  a_masked_silent: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> ((status_r & ~$past(status_r) & $past(all_mask)) == `RST_EVT))
    else $error("A masked counter raised its status bit.");

  a_unmasked_sets: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (|(evt_raw & ~all_mask)) |=> ((status_r & $past(evt_raw & ~all_mask)) == $past(evt_raw & ~all_mask)))
    else $error("An unmasked counter event was lost.");

  a_tagged_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_TAGGED] || i_tx_full[`TX_TAGGED]) && !status_r[`TX_TAGGED] && !o_tx_mask[`TX_TAGGED]
      |=> status_r[`TX_TAGGED])
    else $error("Tagged frame counter event not routed to its bit.");

  a_good_frame_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_tx_full[`TX_GOOD_FRAME] && tx_mask_r[`TX_GOOD_FRAME] && !status_r[`TX_GOOD_FRAME]
      |=> !status_r[`TX_GOOD_FRAME])
    else $error("Masked good-frame counter raised status.");

  a_carrier_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_CARRIER_ERR] || i_tx_full[`TX_CARRIER_ERR]) && !tx_mask_r[`TX_CARRIER_ERR]
      |=> status_r[`TX_CARRIER_ERR])
    else $error("Carrier error counter event not routed to its bit.");

  a_bcast_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_tx_half[`TX_ALL_BCAST] && !tx_mask_r[`TX_ALL_BCAST] |=> status_r[`TX_ALL_BCAST])
    else $error("Broadcast counter event not routed to its bit.");

  a_len_bucket_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_tx_full[`TX_LEN_1024_MAX] && !tx_mask_r[`TX_LEN_1024_MAX] |=> status_r[`TX_LEN_1024_MAX])
    else $error("Length bucket counter event not routed to its bit.");

  a_octet_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_tx_full[`TX_ALL_OCTET] && !tx_mask_r[`TX_ALL_OCTET] |=> status_r[`TX_ALL_OCTET])
    else $error("All-octet counter event not routed to its bit.");

  a_rx_frame_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rx_half[`RX_ALL_FRAME] || i_rx_full[`RX_ALL_FRAME]) && !rx_mask_r[`RX_ALL_FRAME]
      |=> status_r[`STAT_RX_LSB + `RX_ALL_FRAME])
    else $error("Receive frame counter event not routed to its bit.");

  a_irq_follows: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_irq == |(status_r & $past(enable_r))))
    else $error("Interrupt output does not follow enabled status.");

  a_flow_ctrl_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_FLOW_CTRL] || i_tx_full[`TX_FLOW_CTRL]) && !tx_mask_r[`TX_FLOW_CTRL]
      |=> status_r[`TX_FLOW_CTRL])
    else $error("Flow-control frame counter event not routed to its bit.");

  a_exc_defer_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_EXC_DEFER] || i_tx_full[`TX_EXC_DEFER]) && !tx_mask_r[`TX_EXC_DEFER]
      |=> status_r[`TX_EXC_DEFER])
    else $error("Excessive deferral counter event not routed to its bit.");

  a_good_octet_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_GOOD_OCTET] || i_tx_full[`TX_GOOD_OCTET]) && !tx_mask_r[`TX_GOOD_OCTET]
      |=> status_r[`TX_GOOD_OCTET])
    else $error("Good-octet counter event not routed to its bit.");

  a_underflow_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_UNDERFLOW] || i_tx_full[`TX_UNDERFLOW]) && !tx_mask_r[`TX_UNDERFLOW]
      |=> status_r[`TX_UNDERFLOW])
    else $error("Underflow counter event not routed to its bit.");

  a_late_coll_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_LATE_COLL] || i_tx_full[`TX_LATE_COLL]) && !tx_mask_r[`TX_LATE_COLL]
      |=> status_r[`TX_LATE_COLL])
    else $error("Late collision counter event not routed to its bit.");

  a_ucast_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_ALL_UCAST] || i_tx_full[`TX_ALL_UCAST]) && !tx_mask_r[`TX_ALL_UCAST]
      |=> status_r[`TX_ALL_UCAST])
    else $error("Unicast counter event not routed to its bit.");

  a_mcast_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_ALL_MCAST] || i_tx_full[`TX_ALL_MCAST]) && !tx_mask_r[`TX_ALL_MCAST]
      |=> status_r[`TX_ALL_MCAST])
    else $error("Multicast counter event not routed to its bit.");

  a_len_64_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_LEN_UPTO_64] || i_tx_full[`TX_LEN_UPTO_64]) && !tx_mask_r[`TX_LEN_UPTO_64]
      |=> status_r[`TX_LEN_UPTO_64])
    else $error("Shortest length bucket event not routed to its bit.");

  a_good_mcast_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_GOOD_MCAST] || i_tx_full[`TX_GOOD_MCAST]) && !tx_mask_r[`TX_GOOD_MCAST]
      |=> status_r[`TX_GOOD_MCAST])
    else $error("Good multicast counter event not routed to its bit.");

  a_all_frame_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_tx_half[`TX_ALL_FRAME] || i_tx_full[`TX_ALL_FRAME]) && !tx_mask_r[`TX_ALL_FRAME]
      |=> status_r[`TX_ALL_FRAME])
    else $error("All-frame counter event not routed to its bit.");

  a_rx_good_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rx_half[`RX_GOOD_OCTET] || i_rx_full[`RX_GOOD_OCTET]) && !rx_mask_r[`RX_GOOD_OCTET]
      |=> status_r[`STAT_RX_LSB + `RX_GOOD_OCTET])
    else $error("Receive good-octet counter event not routed to its bit.");

  a_rx_octet_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rx_half[`RX_ALL_OCTET] || i_rx_full[`RX_ALL_OCTET]) && !rx_mask_r[`RX_ALL_OCTET]
      |=> status_r[`STAT_RX_LSB + `RX_ALL_OCTET])
    else $error("Receive all-octet counter event not routed to its bit.");

  a_rx_mask_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    seq_wr_rx_mask |=> (o_rx_mask == $past(i_wr_data[`RX_MASK_W-1:0])))
    else $error("Receive mask write did not take.");

  a_rx_rsvd_zero: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rd_en && sel_rx_mask) |=> (o_rd_data == {29'h0, $past(rx_mask_r)}))
    else $error("Receive mask read back wrong or upper bits set.");

  a_enable_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_enable |=> (enable_r == $past(i_wr_data[`EVT_W-1:0])))
    else $error("Interrupt enable write did not take.");

  a_clear_drops: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_clear |=> ((status_r & $past(clr_bits) & ~$past(evt_gated)) == `RST_EVT))
    else $error("Cleared status bit stayed set without a new event.");

  a_status_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rd_en && sel_status) |=> (o_rd_data == to_word($past(status_r))))
    else $error("Status read back wrong.");

  a_rd_idle_zero: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_rd_en |=> (o_rd_data == `RST_WORD))
    else $error("Read data not zero outside a read.");

endmodule : mac_stat_counter_irq_mask
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_irq_mask_defines.svh"
module tb;
  import mac_irq_mask_pkg::*;
  typedef struct {reg_addr_t a; reg_word_t w; reg_word_t e;} row_t;
  logic        i_ref_clk;
  logic        i_rst_n;
  reg_addr_t   i_addr;
  reg_word_t   i_wr_data;
  logic        i_wr_en;
  logic        i_rd_en;
  reg_word_t   o_rd_data;
  logic [24:0] i_tx_half;
  logic [24:0] i_tx_full;
  logic [2:0]  i_rx_half;
  logic [2:0]  i_rx_full;
  logic [24:0] o_tx_mask;
  logic [2:0]  o_rx_mask;
  logic        o_irq;
  int          err_count;
  int          n_tests;
  row_t        rows [6];

  mac_stat_counter_irq_mask u_mac_stat_counter_irq_mask (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_tx_half(i_tx_half),
    .i_tx_full(i_tx_full), .i_rx_half(i_rx_half), .i_rx_full(i_rx_full),
    .o_tx_mask(o_tx_mask), .o_rx_mask(o_rx_mask), .o_irq(o_irq));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic cmp(input reg_word_t got, input reg_word_t exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1; i_addr <= a; i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input reg_addr_t a, output reg_word_t d);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1 d = o_rd_data;
  endtask : rd

  // Pulses one counter event; status index 0..24 is transmit, 25..27 receive.
  task automatic ev(input int i, input logic full);
    logic [27:0] v;
    v = 28'h1 << i;
    @(posedge i_ref_clk);
    i_tx_half <= full ? 25'h0 : v[24:0]; i_tx_full <= full ? v[24:0] : 25'h0;
    i_rx_half <= full ? 3'h0 : v[27:25]; i_rx_full <= full ? v[27:25] : 3'h0;
    @(posedge i_ref_clk);
    i_tx_half <= 25'h0; i_tx_full <= 25'h0; i_rx_half <= 3'h0; i_rx_full <= 3'h0;
    #1;
  endtask : ev

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end

  initial
  begin
    reg_word_t d;
    reg_word_t m;
    i_rst_n = 1'b0; i_addr = 12'h000; i_wr_data = 32'h0; i_wr_en = 1'b0; i_rd_en = 1'b0;
    i_tx_half = 25'h0; i_tx_full = 25'h0; i_rx_half = 3'h0; i_rx_full = 3'h0;
    err_count = 0; n_tests = 0;
    rows = '{'{`OFS_TX_MASK, 32'hFFFFFFFF, 32'h01FFFFFF}, '{`OFS_RX_MASK, 32'hFFFFFFFF, 32'h00000007},
             '{`OFS_IRQ_STATUS, 32'hFFFFFFFF, 32'h0}, '{`OFS_IRQ_CLEAR, 32'hFFFFFFFF, 32'h0},
             '{`OFS_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0FFFFFFF}, '{12'h200, 32'hFFFFFFFF, 32'h0}};
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(`OFS_TX_MASK, d); cmp(d, `RST_WORD);
    rd(`OFS_RX_MASK, d); cmp(d, `RST_WORD);
    cmp({31'h0, o_irq}, 32'h0);
    $display("Reset values done");
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, d); cmp(d, rows[k].e);
    end
    cmp({7'h0, o_tx_mask}, 32'h01FFFFFF);
    cmp({29'h0, o_rx_mask}, 32'h7);
    $display("Register table done");
    wr(`OFS_TX_MASK, 32'h0); wr(`OFS_RX_MASK, 32'h0);
    for (int i = 0; i < 28; i++)
    begin
      m = 32'h1 << i;
      ev(i, i[0]); cmp({31'h0, o_irq}, 32'h1);
      rd(`OFS_IRQ_STATUS, d); cmp(d, m);
      wr(`OFS_IRQ_CLEAR, m);
      @(posedge i_ref_clk); #1 cmp({31'h0, o_irq}, 32'h0);
      if (i < 25) wr(`OFS_TX_MASK, m); else wr(`OFS_RX_MASK, m >> 25);
      ev(i, 1'b0); ev(i, 1'b1);
      rd(`OFS_IRQ_STATUS, d); cmp(d, 32'h0);
      cmp({31'h0, o_irq}, 32'h0);
      ev(i == 0 ? 1 : 0, 1'b1);
      rd(`OFS_IRQ_STATUS, d); cmp(d, i == 0 ? 32'h2 : 32'h1);
      wr(`OFS_IRQ_CLEAR, 32'h0FFFFFFF);
      wr(`OFS_TX_MASK, 32'h0); wr(`OFS_RX_MASK, 32'h0);
    end
    $display("Per-counter gating done");
    wr(`OFS_IRQ_ENABLE, 32'h0);
    ev(7, 1'b1); cmp({31'h0, o_irq}, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h80);
    repeat (2) @(posedge i_ref_clk);
    #1 cmp({31'h0, o_irq}, 32'h1);
    wr(`OFS_TX_MASK, 32'h00ABCDEF); wr(`OFS_RX_MASK, 32'h5);
    #1 cmp({4'h0, o_rx_mask, o_tx_mask}, 32'h0AABCDEF);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    #1 cmp({4'h0, o_rx_mask, o_tx_mask}, 32'h0);
    cmp({31'h0, o_irq}, 32'h0);
    rd(`OFS_IRQ_STATUS, d); cmp(d, 32'h0);
    $display("Enable and mid-run reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
